// ---- amcsp_pkg.sv ----
// Shared constants and types of the converter mux and serial control block
package amcsp_pkg;

  // ==========================================================================
  // Configuration word layout, the first bit shifted in lands in bit 6
  // ==========================================================================
  localparam int         CFG_W     = 7;      // Bits in a configuration word
  localparam int         CFG_SD    = 6;      // Single-ended (1) or differential (0)
  localparam int         CFG_OS    = 5;      // Odd/sign select
  localparam int         CFG_S1    = 4;      // Pair select, high bit
  localparam int         CFG_S0    = 3;      // Pair select, low bit
  localparam int         CFG_COM   = 2;      // Input seven used as common minus
  localparam int         CFG_UNI   = 1;      // Unipolar (1) or bipolar (0)
  localparam int         CFG_SLP   = 0;      // Sleep request
  localparam logic [6:0] CFG_RST   = 7'h00;  // Word in force after reset
  localparam logic [2:0] COMMON_CH = 3'h7;   // Input that doubles as common

  // ==========================================================================
  // Conversion timing
  // ==========================================================================
  localparam int         CLK_MHZ      = 100;   // Rate of mclk_i
  localparam int         CONV_TIME_NS = 3500;  // Longest conversion time
  localparam int         CONV_CYC     = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam logic [8:0] CONV_CNT     = 9'(CONV_CYC);  // Cycles per conversion

  // ==========================================================================
  // Control states
  // ==========================================================================
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h1,
    ST_CONV  = 3'h2,
    ST_SLEEP = 3'h4
  } amcsp_state_type;

endpackage

// ---- amcsp_link_if.sv ----
// Carrier between the control logic and the shift-clock serial port
`timescale 1ns/1ps
`default_nettype none

interface amcsp_link_if
#(
  parameter int W = 16
);
  logic [W-1:0] result;      // Formatted result, held stable between conversions
  logic [6:0]   cfg_word;    // Last complete configuration word
  logic         cfg_toggle;  // Flips once per complete word
  logic         sdo;         // Serial data bit presented to the pin

  // Control side on mclk_i
  modport ctrl
  (
    output result,
    input  cfg_word,
    input  cfg_toggle,
    input  sdo
  );

  // Serial port side on the shift clock
  modport link
  (
    input  result,
    output cfg_word,
    output cfg_toggle,
    output sdo
  );
endinterface

`default_nettype wire

// ---- amcsp_serial_port.sv ----
// Shift-clock serial port: configuration word in, conversion result out
`timescale 1ns/1ps
`default_nettype none

module amcsp_serial_port
  import amcsp_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic  sck_i,        // Shift clock from the host
  input  wire logic  frame_rst_i,  // High outside a frame or in reset
  input  wire logic  sys_rst_i,    // System reset
  input  wire logic  sdi_i,        // Serial data in
  amcsp_link_if.link lnk           // Toward the control logic
);

  localparam int IW = $clog2(W) + 1;

  logic [CFG_W-1:0] shift_q;    // Incoming bits
  logic [2:0]       in_cnt_q;   // Bits taken this frame
  logic [IW-1:0]    out_idx_q;  // Result bits already shifted out

  // ==========================================================================
  // Input side, sampled on the rising shift clock
  // ==========================================================================
  // Bit count, cleared by the frame itself since the clock stops between frames
  always_ff @(posedge sck_i or posedge frame_rst_i)
  begin
    if (frame_rst_i)
      in_cnt_q <= 3'h0;
    else if (in_cnt_q != 3'(CFG_W))
      in_cnt_q <= in_cnt_q + 3'h1;
  end

  // Shift register, first bit ends in the top position
  always_ff @(posedge sck_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      shift_q <= CFG_RST;
    else
      shift_q <= {shift_q[CFG_W-2:0], sdi_i};
  end

  // Publish a complete word and flip the toggle for the crossing
  always_ff @(posedge sck_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lnk.cfg_word   <= CFG_RST;
      lnk.cfg_toggle <= 1'b0;
    end
    else if (in_cnt_q == 3'(CFG_W - 1))
    begin
      lnk.cfg_word   <= {shift_q[CFG_W-2:0], sdi_i};
      lnk.cfg_toggle <= ~lnk.cfg_toggle;
    end
  end

  // ==========================================================================
  // Output side, advanced on the falling shift clock
  // ==========================================================================
  // Index restarts at each frame so the top bit shows as the frame opens
  always_ff @(negedge sck_i or posedge frame_rst_i)
  begin
    if (frame_rst_i)
      out_idx_q <= '0;
    else if (out_idx_q != IW'(W))
      out_idx_q <= out_idx_q + IW'(1);
  end

  // Top bit first, zeros once the word is exhausted
  assign lnk.sdo = (out_idx_q < IW'(W)) ? lnk.result[W - 1 - int'(out_idx_q)] : 1'b0;

endmodule

`default_nettype wire

// ---- amcsp_ctrl.sv ----
// Converter control: mux decode, conversion sequencing and result format
//
// What this block does
// - Differential mode picks adjacent pair by select bits
// - Odd/sign bit swaps differential pair polarity
// - Single-ended without common: input against ground
// - Common option in single-ended mode: input seven becomes negative side
// - Rising select_and_convert edge starts a conversion
// - Low select_and_convert after conversion opens serial port
// - Bipolar gives two's complement, unipolar straight binary
// - Seven-bit word: sd, os, s1, s0, com, uni, sleep
// - New word applies to the following conversion
// - Start requests ignored while converting
// - Sleep bit powers converter down until cleared
`timescale 1ns/1ps
`default_nettype none

module amcsp_ctrl
  import amcsp_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic         mclk_i,                // System clock
  input  wire logic         sys_rst_i,             // Asynchronous reset, active high
  input  wire logic         ce_i,                  // Clock enable for all mclk state
  input  wire logic         select_and_convert_i,  // Start / frame pin
  input  wire logic         sck_i,                 // Shift clock pin
  input  wire logic         sdi_i,                 // Serial data in pin
  input  wire logic [W-1:0] raw_code_i,            // Offset-binary code from the converter core
  output logic              sdo_o,                 // Serial data out pin
  output logic              sdo_oe_n_o,            // Low while the data pin is driven
  output logic [2:0]        pos_ch_o,              // Input routed to the positive side
  output logic [2:0]        neg_ch_o,              // Input routed to the negative side
  output logic              neg_gnd_o,             // Negative side tied to ground
  output logic              unipolar_o,            // Unipolar range in force
  output logic              sleep_o,               // Converter powered down
  output logic              conv_start_o,          // One-cycle pulse at conversion start
  output logic              busy_o                 // Conversion in progress
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  amcsp_link_if #(.W(W)) lnk ();         // Carrier to the serial port

  logic             cs_s1_q;             // Pin synchroniser, first stage
  logic             cs_s2_q;             // Pin synchroniser, second stage
  logic             cs_s3_q;             // Delayed copy for edge detect
  logic             tg_s1_q;             // Word toggle, first stage
  logic             tg_s2_q;             // Word toggle, second stage
  logic             tg_s3_q;             // Delayed copy for change detect
  logic             cs_rise;             // Start edge seen
  logic             tgl_evt;             // New word arrived
  logic [CFG_W-1:0] pend_q;              // Word waiting for the next start
  logic [CFG_W-1:0] cfg_nxt;             // Word a start would take
  logic [CFG_W-1:0] act_q;               // Word in force
  amcsp_state_type  state_q;             // Control state
  logic [8:0]       cnt_q;               // Conversion cycles left
  logic             frame_rst;           // Serial port frame reset
  logic             start_ok;            // A start request is accepted

  // ==========================================================================
  // Serial port on the shift clock
  // ==========================================================================
  // The pin itself ends each frame, so nothing there waits for a missing edge
  assign frame_rst = sys_rst_i | select_and_convert_i;

  amcsp_serial_port #(.W(W)) u_port
  (
    .sck_i       (sck_i),
    .frame_rst_i (frame_rst),
    .sys_rst_i   (sys_rst_i),
    .sdi_i       (sdi_i),
    .lnk         (lnk.link)
  );

  // Data bit leaves through the port's index mux so the top bit meets the frame
  assign sdo_o = lnk.sdo;

  // ==========================================================================
  // Crossings into mclk
  // ==========================================================================
  // Two flops for the pin, a third only for the edge
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cs_s1_q <= 1'b0;
      cs_s2_q <= 1'b0;
      cs_s3_q <= 1'b0;
    end
    else if (ce_i)
    begin
      cs_s1_q <= select_and_convert_i;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // Toggle crossing for a finished configuration word
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
    end
    else if (ce_i)
    begin
      tg_s1_q <= lnk.cfg_toggle;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
    end
  end

  assign cs_rise  = cs_s2_q & ~cs_s3_q;
  assign tgl_evt  = tg_s2_q ^ tg_s3_q;
  assign cfg_nxt  = tgl_evt ? lnk.cfg_word : pend_q;
  assign start_ok = cs_rise && (state_q != ST_CONV);

  // ==========================================================================
  // Configuration words
  // ==========================================================================
  // A word read in during a frame waits here; the word is stable by then
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pend_q <= CFG_RST;
    else if (ce_i && tgl_evt)
      pend_q <= lnk.cfg_word;
  end

  // The waiting word takes over only at the next accepted start, whether it begins a conversion or sleep
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      act_q <= CFG_RST;
    else if (ce_i && start_ok)
      act_q <= cfg_nxt;
  end

  // ==========================================================================
  // Conversion sequencing
  // ==========================================================================
  // Idle and sleep both wait for a start; the new word decides which follows
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q      <= ST_IDLE;
      cnt_q        <= 9'h000;
      conv_start_o <= 1'b0;
    end
    else if (ce_i)
    begin
      conv_start_o <= 1'b0;
      case (state_q)
        ST_IDLE, ST_SLEEP:
        begin
          if (start_ok && cfg_nxt[CFG_SLP])
            state_q <= ST_SLEEP;
          else if (start_ok)
          begin
            state_q      <= ST_CONV;
            cnt_q        <= CONV_CNT;
            conv_start_o <= 1'b1;
          end
        end
        ST_CONV:
        begin
          // Further edges fall through untouched until the count runs out
          cnt_q <= cnt_q - 9'h001;
          if (cnt_q == 9'h001)
            state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
          cnt_q   <= 9'h000;
        end
      endcase
    end
  end

  // Result latch; held steady for the whole read-out frame
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      lnk.result <= '0;
    else if (ce_i && state_q == ST_CONV && cnt_q == 9'h001)
    begin
      if (act_q[CFG_UNI])
        lnk.result <= raw_code_i;
      else
        lnk.result <= {~raw_code_i[W-1], raw_code_i[W-2:0]};
    end
  end

  // Status outputs
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      busy_o     <= 1'b0;
      sleep_o    <= 1'b0;
      unipolar_o <= 1'b0;
      sdo_oe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      busy_o     <= (state_q == ST_CONV);
      sleep_o    <= (state_q == ST_SLEEP);
      unipolar_o <= act_q[CFG_UNI];
      sdo_oe_n_o <= cs_s2_q;
    end
  end

  // ==========================================================================
  // Input multiplexer decode
  // ==========================================================================
  // Reserved differential-with-common is handled as plain differential
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pos_ch_o  <= 3'h0;
      neg_ch_o  <= 3'h1;
      neg_gnd_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pos_ch_o <= {act_q[CFG_S1], act_q[CFG_S0], act_q[CFG_OS]};
      if (!act_q[CFG_SD])
      begin
        // Differential pair, sign bit swaps the members
        neg_ch_o  <= {act_q[CFG_S1], act_q[CFG_S0], ~act_q[CFG_OS]};
        neg_gnd_o <= 1'b0;
      end
      else if (act_q[CFG_COM])
      begin
        // Single-ended against the common pin
        neg_ch_o  <= COMMON_CH;
        neg_gnd_o <= 1'b0;
      end
      else
      begin
        // Single-ended against ground
        neg_ch_o  <= 3'h0;
        neg_gnd_o <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_diff_pair: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && !act_q[CFG_SD] |=> !neg_gnd_o && pos_ch_o[2:1] == neg_ch_o[2:1]
      && pos_ch_o[2:1] == $past(act_q[CFG_S1:CFG_S0]))
    else $error("Differential pair not adjacent");

  a_diff_polarity: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && !act_q[CFG_SD] |=> pos_ch_o[0] == $past(act_q[CFG_OS]) && neg_ch_o[0] != pos_ch_o[0])
    else $error("Differential polarity wrong");

  a_single_gnd: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && act_q[CFG_SD] && !act_q[CFG_COM] |=> neg_gnd_o
      && pos_ch_o == {$past(act_q[CFG_S1:CFG_S0]), $past(act_q[CFG_OS])})
    else $error("Single-ended input not against ground");

  a_common_neg: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && act_q[CFG_SD] && act_q[CFG_COM] |=> !neg_gnd_o && neg_ch_o == COMMON_CH)
    else $error("Common pin not on negative side");

  a_start_conv: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && start_ok && !cfg_nxt[CFG_SLP] |=> conv_start_o ##1 busy_o)
    else $error("Start edge did not begin a conversion");

  a_no_restart: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && state_q == ST_CONV && cnt_q > 9'h001 |=> state_q == ST_CONV && cnt_q == $past(cnt_q) - 9'h001)
    else $error("Conversion restarted or cut short");

  a_port_enable: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && !cs_s2_q |=> !sdo_oe_n_o)
    else $error("Serial output not enabled in frame");

  a_result_fmt: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && state_q == ST_CONV && cnt_q == 9'h001 |=> lnk.result == ($past(act_q[CFG_UNI])
      ? $past(raw_code_i) : {~$past(raw_code_i[W-1]), $past(raw_code_i[W-2:0])}))
    else $error("Result format wrong");

  a_cfg_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !(ce_i && start_ok) |=> act_q == $past(act_q))
    else $error("Configuration changed outside a start");

  a_sleep_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && state_q == ST_SLEEP && !(start_ok && !cfg_nxt[CFG_SLP]) |=> state_q == ST_SLEEP ##1 !busy_o)
    else $error("Converter left sleep without a clearing word");

endmodule

`default_nettype wire

// ---- amcsp_host_model.sv ----
// Host serial master model: frame pin, shift clock, data in and result capture
`timescale 1ns/1ps
`default_nettype none

module amcsp_host_model
#(
  parameter int W = 16
)
(
  input  wire logic mclk_i,  // System clock, pin moves follow its fall
  input  wire logic sdo_i,   // Serial data from the device
  output var  logic cs_o,    // Start and frame pin
  output var  logic sck_o,   // Shift clock, still outside frames
  output var  logic sdi_o    // Serial data to the device
);
  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  // Quiet pins at time zero
  initial
  begin
    cs_o  = 1'b0;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end

  // Rising frame pin asks for one sample
  task automatic start_conv();
    @(negedge mclk_i);
    cs_o = 1'b1;
  endtask

  // Short low pulse, a second start while a conversion runs
  task automatic restart_pulse();
    @(negedge mclk_i);
    cs_o = 1'b0;
    repeat (3) @(negedge mclk_i);
    cs_o = 1'b1;
  endtask

  // Open a frame, send n bits of the word MSB first, capture the result
  task automatic frame(input logic [6:0] w, input int n, output logic [W-1:0] rd);
    int k;
    rd = '0;
    @(negedge mclk_i);
    cs_o = 1'b0;
    repeat (5) @(negedge mclk_i);
    #3;
    for (k = 0; k < n; k++)
    begin
      sdi_o = (k < 7) ? w[6-k] : 1'($urandom);
      #6;
      // Result bit taken just before the rise, well after the fall that moved it
      rd[W-1-k] = sdo_i;
      sck_o = 1'b1;
      #6 sck_o = 1'b0;
    end
    // Data line toggles once released so no stale level lingers
    sdi_o = ~sdi_o;
    @(negedge mclk_i);
  endtask
endmodule

`default_nettype wire

// ---- amcsp_tb_top.sv ----
// Self-checking bench of the converter mux and serial control block
`timescale 1ns/1ps
`default_nettype none

module amcsp_tb_top
  import amcsp_pkg::*;
;
  localparam int W    = 16;     // Result width under test
  localparam int TMAX = 60000;  // Cycle ceiling for a hang
  localparam int FREEZE = 5;    // Cycles with the clock enable low per conversion

  logic         mclk_i;       // System clock
  logic         sys_rst_i;    // Reset
  logic         ce_i;         // Clock enable
  logic [W-1:0] raw_code_i;   // Code from the converter core
  wire          cs_w;         // Frame pin
  wire          sck_w;        // Shift clock
  wire          sdi_w;        // Data in
  logic         sdo_o;        // Data out
  logic         sdo_oe_n_o;   // Data pin enable
  logic [2:0]   pos_ch_o;     // Positive input
  logic [2:0]   neg_ch_o;     // Negative input
  logic         neg_gnd_o;    // Negative on ground
  logic         unipolar_o;   // Range in force
  logic         sleep_o;      // Powered down
  logic         conv_start_o; // Start pulse
  logic         busy_o;       // Converting
  int           num_errors;   // Mismatches
  int           checks_done;  // Comparisons
  int           cycles;       // Clock cycles run
  int           starts;       // Start pulses seen
  int           busy_len;     // Busy cycles seen
  logic [W-1:0] exp_res;      // Expected result
  logic [W-1:0] rd;           // Result read back
  logic [6:0]   w;            // Word of this step

  // ==========================================================================
  // Clock, instances and monitors
  // ==========================================================================
  initial mclk_i = 1'b0;
  always #5 mclk_i = ~mclk_i;

  amcsp_ctrl #(.W(W)) amcsp_ctrl_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .select_and_convert_i(cs_w), .sck_i(sck_w), .sdi_i(sdi_w), .raw_code_i(raw_code_i),
    .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .pos_ch_o(pos_ch_o), .neg_ch_o(neg_ch_o),
    .neg_gnd_o(neg_gnd_o), .unipolar_o(unipolar_o), .sleep_o(sleep_o),
    .conv_start_o(conv_start_o), .busy_o(busy_o));

  amcsp_host_model #(.W(W)) amcsp_host_model_i (.mclk_i(mclk_i), .sdo_i(sdo_o),
    .cs_o(cs_w), .sck_o(sck_w), .sdi_o(sdi_w));

  // Counts starts and busy cycles, cuts a hang short
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (conv_start_o === 1'b1)
      starts <= starts + 1;
    if (busy_o === 1'b1)
      busy_len <= busy_len + 1;
    if (cycles == TMAX)
    begin
      num_errors++;
      final_report();
    end
  end

  // ==========================================================================
  // Reference model and checks
  // ==========================================================================
  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected routing {pos, neg, ground}
  function automatic logic [6:0] mux_of(input logic [6:0] cw);
    logic [2:0] p;
    p = {cw[4:3], cw[5]};
    if (!cw[6])
      return {p, cw[4:3], ~cw[5], 1'b0};
    if (cw[2])
      return {p, COMMON_CH, 1'b0};
    return {p, 3'h0, 1'b1};
  endfunction

  // One start with the word in force, checked to the end of conversion
  task automatic convert(input logic [6:0] cw);
    int s0;
    int b0;
    int k;
    s0 = starts;
    b0 = busy_len;
    @(negedge mclk_i);
    raw_code_i = W'($urandom);
    amcsp_host_model_i.start_conv();
    if (cw[0])
    begin
      repeat (10) @(negedge mclk_i);
      check(starts - s0, 0);
      check(sleep_o, 1'b1);
      return;
    end
    for (k = 0; k < 10 && starts == s0; k++)
      @(negedge mclk_i);
    repeat (2) @(negedge mclk_i);
    check({pos_ch_o, neg_ch_o, neg_gnd_o}, mux_of(cw));
    check({unipolar_o, sleep_o, busy_o, sdo_oe_n_o}, {cw[1], 3'b011});
    amcsp_host_model_i.restart_pulse();
    // Clock enable low freezes the count, so busy lasts that much longer
    @(negedge mclk_i);
    ce_i = 1'b0;
    repeat (FREEZE) @(negedge mclk_i);
    ce_i = 1'b1;
    for (k = 0; k < 400 && busy_o !== 1'b0; k++)
      @(negedge mclk_i);
    check(busy_len - b0, CONV_CYC + FREEZE);
    check(starts - s0, 1);
    exp_res = cw[1] ? raw_code_i : raw_code_i ^ {1'b1, {(W-1){1'b0}}};
  endtask

  // Read the last result while shifting in the next word
  task automatic read_frame(input logic [6:0] nw, input int n);
    amcsp_host_model_i.frame(nw, n, rd);
    check(sdo_oe_n_o, 1'b0);
    if (n == W)
      check(rd, exp_res);
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    num_errors  = 0;
    checks_done = 0;
    cycles      = 0;
    starts      = 0;
    busy_len    = 0;
    raw_code_i  = '0;
    ce_i        = 1'b1;
    sys_rst_i   = 1'b1;
    void'($urandom(32'h389379da));
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    @(negedge mclk_i);
    check({sdo_oe_n_o, busy_o, sleep_o, unipolar_o}, 4'h0);
    check({pos_ch_o, neg_ch_o, neg_gnd_o}, mux_of(7'h00));
    convert(7'h00);
    // Every select, sign and common combination except differential with common and single-ended input seven with common
    for (int i = 0; i < 32; i++)
    begin
      w = {i[4:0], 1'($urandom), 1'b0};
      if ((!w[6] && w[2]) || w[6:2] == 5'h1f)
        continue;
      read_frame(w, W);
      convert(w);
    end
    // Sleep, wake, then a short frame that leaves the word alone
    read_frame(7'h03, W);
    convert(7'h03);
    read_frame(7'h5a, W);
    convert(7'h5a);
    read_frame(7'h2a, 4);
    convert(7'h5a);
    final_report();
  end
endmodule

`default_nettype wire
